// *** pkg/bdcr_defines.svh ***
// Offsets, field positions, reset values and timing counts for the bridge config bank
// Assumes a 100 MHz MCLK and a 32-bit AXI4-Lite register port
`ifndef BDCR_DEFINES_SVH
`define BDCR_DEFINES_SVH
`define BDCR_OFF_PWMSRC 8'h08
`define BDCR_OFF_SEQUENCER_MAPPING 8'h0C
`define BDCR_OFF_DELAY 8'h10
`define BDCR_OFF_PUMP 8'h14
`define BDCR_OFF_PCLK 8'h18
`define BDCR_OFF_PROT 8'h1C
`define BDCR_RST_PWMSRC 32'h00261504
`define BDCR_RST_PCLK 32'h00014A16
`define BDCR_RST_PROT 32'h01000000
`define BDCR_MASK_PWMSRC 32'h00770000
`define BDCR_MASK_SEQUENCER_MAPPING 32'h00010101
`define BDCR_MASK_DELAY 32'h000F0000
`define BDCR_MASK_PUMP 32'h00030F05
`define BDCR_MASK_PCLK 32'h00037F1F
`define BDCR_MASK_PROT 32'h1F333333
`define BDCR_LS3_LSB 16
`define BDCR_HS3_LSB 20
`define BDCR_DLY_VALID 24
`define BDCR_DLY_CLR 25
`define BDCR_DLY_SET 26
`define BDCR_DLY_DIR 19
`define BDCR_DLY_CH_LSB 16
`define BDCR_UV_SDEN 24
`define BDCR_STEP_NS 50
`define BDCR_CLK_NS 10
`define BDCR_STEP_CYC (`BDCR_STEP_NS / `BDCR_CLK_NS)
`define BDCR_PUMP_IN_MHZ 20
`define BDCR_PRE_CYC (100 / `BDCR_PUMP_IN_MHZ)
`define BDCR_FILT_BASE_US 4
`define BDCR_FILT_BASE_CYC (`BDCR_FILT_BASE_US * 1000 / `BDCR_CLK_NS)
`endif

// *** pkg/bdcr_pkg.sv ***
// Types shared by the bridge config bank
// Assumes nothing beyond a SystemVerilog tool
package bdcr_pkg;
  // Delay timer states
  typedef enum logic [1:0] {BDCR_IDLE, BDCR_ARMED, BDCR_COUNT} bdcr_meas_t;
endpackage

// *** core/bdcr_regs.sv ***
// Bridge driver config bank: source select, sequencer map, delay timer, pump control
// Assumes AXI4-Lite master on MCLK; analog status inputs come from other domains
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bdcr_defines.svh"
module bdcr_regs
(
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Bridge side inputs (same clock)
  input wire logic PWM_ENABLES_ANY,
  input wire logic [7:0] PWM_IN_LOW,
  input wire logic [7:0] PWM_IN_HIGH,
  // Asynchronous inputs from analog
  input wire logic [2:0] ACTIVE_HIGH_SIDE,
  input wire logic SWITCH_ON_EVENT,
  input wire logic [5:0] GATE_ON,
  input wire logic PUMP_READY,
  input wire logic PUMP_UV_CONV,
  input wire logic PUMP_UV_COMP,
  input wire logic SUPPLY_LOW,
  input wire logic BRIDGE_REQ,
  // Outputs
  output logic PHASE3_LOW_PWM,
  output logic PHASE3_HIGH_PWM,
  output logic [2:0] SEQ_ROUTE,
  output logic PUMP_POWER_ON,
  output logic PUMP_FALL_THRESHOLD,
  output logic PUMP_SINGLE_STAGE,
  output logic PUMP_UV,
  output logic BRIDGE_ENABLE,
  output logic PUMP_CLK
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [31:0] pwmsrc; // Phase-3 source fields
  logic [31:0] sequencer_mapping; // Route bits
  logic [2:0] act_side; // Captured active sides
  logic [9:0] delay_result; // Timer result
  logic [3:0] delay_cfg; // Direction and channel
  logic delay_valid; // Valid flag
  logic [31:0] pump; // Pump control
  logic [31:0] pclk; // Pump clock control
  logic [31:0] prot; // Protection control
  // Synchronisers for analog inputs
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic sw_on_prev; // Switch-on edge detect
  logic gate_prev; // Selected gate edge detect
  ////////////////////////////////////////////////////////////////////////////////
  // Bus channel state
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wmask;
  assign AWREADY = !aw_full && !BVALID;
  assign WREADY = !w_full && !BVALID;
  assign ARREADY = !RVALID;
  assign do_write = aw_full && w_full && !BVALID;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign BRESP = 2'h0;
  // Address and data latches, taken in either order
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (CE)
    begin
      if (AWVALID && AWREADY)
      begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR;
      end
      else if (do_write)
        aw_full <= 1'b0;
      if (WVALID && WREADY)
      begin
        w_full <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      else if (do_write)
        w_full <= 1'b0;
    end
  end
  // Write response, always OKAY; writes to unmapped words are dropped
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      BVALID <= 1'b0;
    else if (CE)
    begin
      if (do_write)
        BVALID <= 1'b1;
      else if (BREADY)
        BVALID <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Write decode strobes
  logic wr_src, wr_seq, wr_dly, wr_pump, wr_pclk, wr_prot;
  always_comb
  begin
    wr_src = do_write && aw_addr == `BDCR_OFF_PWMSRC;
    wr_seq = do_write && aw_addr == `BDCR_OFF_SEQUENCER_MAPPING;
    wr_dly = do_write && aw_addr == `BDCR_OFF_DELAY;
    wr_pump = do_write && aw_addr == `BDCR_OFF_PUMP;
    wr_pclk = do_write && aw_addr == `BDCR_OFF_PCLK;
    wr_prot = do_write && aw_addr == `BDCR_OFF_PROT;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Control registers with masked byte writes
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      pwmsrc <= `BDCR_RST_PWMSRC & `BDCR_MASK_PWMSRC;
      sequencer_mapping <= 32'h00000000;
      pump <= 32'h00000000;
      pclk <= `BDCR_RST_PCLK;
      prot <= `BDCR_RST_PROT;
    end
    else if (CE)
    begin
      // Source fields locked while any PWM enable is set
      if (wr_src && !PWM_ENABLES_ANY)
        pwmsrc <= (pwmsrc & ~wmask) | (w_data & wmask & `BDCR_MASK_PWMSRC);
      if (wr_seq)
        sequencer_mapping <= (sequencer_mapping & ~wmask) | (w_data & wmask & `BDCR_MASK_SEQUENCER_MAPPING);
      if (wr_pump)
        pump <= (pump & ~wmask) | (w_data & wmask & `BDCR_MASK_PUMP);
      if (wr_pclk)
        pclk <= (pclk & ~wmask) | (w_data & wmask & `BDCR_MASK_PCLK);
      if (wr_prot)
        prot <= (prot & ~wmask) | (w_data & wmask & `BDCR_MASK_PROT);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for analog inputs
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      sync_a <= 14'h0000;
      sync_b <= 14'h0000;
    end
    else if (CE)
    begin
      sync_a <= {BRIDGE_REQ, SUPPLY_LOW, PUMP_UV_COMP, PUMP_UV_CONV, PUMP_READY,
                 SWITCH_ON_EVENT, GATE_ON, ACTIVE_HIGH_SIDE[2:1]};
      sync_b <= sync_a;
    end
  end
  logic [2:0] act_s;
  logic sw_on_s, ready_s, uvconv_s, uvcomp_s, vlow_s, breq_s;
  logic [5:0] gate_s;
  logic act0_a, act0_b;
  assign {breq_s, vlow_s, uvcomp_s, uvconv_s, ready_s, sw_on_s, gate_s} = sync_b[13:2];
  assign act_s = {sync_b[1:0], act0_b};
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      act0_a <= 1'b0;
      act0_b <= 1'b0;
    end
    else if (CE)
    begin
      act0_a <= ACTIVE_HIGH_SIDE[0];
      act0_b <= act0_a;
    end
  end
  // Capture active side on switch-on rising edge
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      act_side <= 3'h0;
      sw_on_prev <= 1'b0;
    end
    else if (CE)
    begin
      sw_on_prev <= sw_on_s;
      if (sw_on_s && !sw_on_prev)
        act_side <= act_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Delay measurement timer
  logic [2:0] ch;
  logic ch_on;
  logic gate_sel;
  logic gate_edge;
  logic gate_end; // Opposite edge that ends a count
  logic [2:0] step_cnt;
  bdcr_pkg::bdcr_meas_t meas;
  assign ch = delay_cfg[2:0];
  assign ch_on = ch[1:0] != 2'h0;
  // Low side on codes 1-3, high side on 5-7
  assign gate_sel = ch_on ? gate_s[{ch[2], 2'h0} + {1'b0, ch[1:0]} - 3'h1 - {2'h0, ch[2]}] : 1'b0;
  assign gate_edge = delay_cfg[3] ? (gate_sel && !gate_prev) : (!gate_sel && gate_prev);
  // The opposite transition of the selected gate stops the count
  assign gate_end = delay_cfg[3] ? (!gate_sel && gate_prev) : (gate_sel && !gate_prev);
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      delay_cfg <= 4'h0;
      delay_valid <= 1'b0;
      delay_result <= 10'h000;
      step_cnt <= 3'h0;
      gate_prev <= 1'b0;
      meas <= bdcr_pkg::BDCR_IDLE;
    end
    else if (CE)
    begin
      gate_prev <= gate_sel;
      if (wr_dly && w_strb[2])
        delay_cfg <= w_data[19:16];
      // Set and a finished count both win over a clear in the same cycle
      if (wr_dly && w_strb[3] && w_data[`BDCR_DLY_SET])
        delay_valid <= 1'b1;
      else if (meas == bdcr_pkg::BDCR_COUNT && gate_end)
        delay_valid <= 1'b1;
      else if (wr_dly && w_strb[3] && w_data[`BDCR_DLY_CLR])
        delay_valid <= 1'b0;
      case (meas)
        bdcr_pkg::BDCR_IDLE:
        begin
          // Cleared flag with a channel arms a measurement
          if (!delay_valid && ch_on)
            meas <= bdcr_pkg::BDCR_ARMED;
        end
        bdcr_pkg::BDCR_ARMED:
        begin
          if (!ch_on || delay_valid)
            meas <= bdcr_pkg::BDCR_IDLE;
          else if (gate_edge)
          begin
            meas <= bdcr_pkg::BDCR_COUNT;
            delay_result <= 10'h000;
            step_cnt <= 3'h0;
          end
        end
        bdcr_pkg::BDCR_COUNT:
        begin
          if (!ch_on || delay_valid || gate_end)
            meas <= bdcr_pkg::BDCR_IDLE;
          else if (step_cnt == 3'(`BDCR_STEP_CYC - 1))
          begin
            step_cnt <= 3'h0;
            if (delay_result != 10'h3FF)
              delay_result <= delay_result + 10'h001;
          end
          else
            step_cnt <= step_cnt + 3'h1;
        end
        default: meas <= bdcr_pkg::BDCR_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Undervoltage filter and bridge gating
  logic uv_raw;
  logic [15:0] filt_cnt;
  logic [15:0] filt_lim;
  assign uv_raw = pump[9] ? uvcomp_s : uvconv_s;
  assign filt_lim = 16'(`BDCR_FILT_BASE_CYC) << pump[11:10];
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      filt_cnt <= 16'h0000;
      PUMP_UV <= 1'b0;
    end
    else if (CE)
    begin
      if (!uv_raw)
      begin
        filt_cnt <= 16'h0000;
        PUMP_UV <= 1'b0;
      end
      else if (filt_cnt >= filt_lim - 16'h0001)
        PUMP_UV <= 1'b1;
      else
        filt_cnt <= filt_cnt + 16'h0001;
    end
  end
  // Bridge enable gated by ready and undervoltage shutdown
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      BRIDGE_ENABLE <= 1'b0;
    else if (CE)
    begin
      if (!breq_s)
        BRIDGE_ENABLE <= 1'b0;
      else if (prot[`BDCR_UV_SDEN] && PUMP_UV)
        BRIDGE_ENABLE <= 1'b0;
      else if (pump[2] && (PUMP_UV || !ready_s))
        BRIDGE_ENABLE <= BRIDGE_ENABLE && !PUMP_UV;
      else
        BRIDGE_ENABLE <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Static pump outputs and source muxes
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      PUMP_POWER_ON <= 1'b0;
      PUMP_FALL_THRESHOLD <= 1'b0;
      PUMP_SINGLE_STAGE <= 1'b0;
      SEQ_ROUTE <= 3'h0;
      PHASE3_LOW_PWM <= 1'b0;
      PHASE3_HIGH_PWM <= 1'b0;
    end
    else if (CE)
    begin
      PUMP_POWER_ON <= pump[0];
      PUMP_FALL_THRESHOLD <= pump[8];
      // Auto stage follows supply, else fixed selection
      PUMP_SINGLE_STAGE <= pump[17] ? vlow_s : pump[16];
      SEQ_ROUTE <= {sequencer_mapping[16], sequencer_mapping[8], sequencer_mapping[0]};
      // Code 3 low side is the inverted compare input
      PHASE3_LOW_PWM <= (pwmsrc[18:16] == 3'h3) ? !PWM_IN_LOW[3] : PWM_IN_LOW[pwmsrc[18:16]];
      PHASE3_HIGH_PWM <= PWM_IN_HIGH[pwmsrc[22:20]];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pump clock divider with dithering
  logic [2:0] pre_cnt;
  logic [6:0] div_cnt;
  logic dith_sel;
  logic [6:0] bound;
  assign bound = dith_sel ? {pclk[14:13], pclk[4:0]} : {pclk[14:13], pclk[12:8]};
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      pre_cnt <= 3'h0;
      div_cnt <= 7'h00;
      dith_sel <= 1'b0;
      PUMP_CLK <= 1'b0;
    end
    else if (CE)
    begin
      if (!pclk[16] || pclk[14:13] == 2'h0)
      begin
        PUMP_CLK <= pclk[17];
        pre_cnt <= 3'h0;
        div_cnt <= 7'h00;
      end
      else if (pre_cnt == 3'(`BDCR_PRE_CYC - 1))
      begin
        pre_cnt <= 3'h0;
        // Half period of bound ticks, bound swaps each full period
        if (div_cnt >= bound - 7'h01)
        begin
          div_cnt <= 7'h00;
          PUMP_CLK <= !PUMP_CLK;
          if (PUMP_CLK)
            dith_sel <= !dith_sel;
        end
        else
          div_cnt <= div_cnt + 7'h01;
      end
      else
        pre_cnt <= pre_cnt + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd;
  logic rd_bad;
  always_comb
  begin
    rd_bad = 1'b0;
    case (ARADDR)
      `BDCR_OFF_PWMSRC: rd = pwmsrc;
      `BDCR_OFF_SEQUENCER_MAPPING: rd = sequencer_mapping | {14'h0000, act_side[2], 7'h00, act_side[1], 7'h00,
                                        act_side[0], 1'b0};
      `BDCR_OFF_DELAY: rd = {7'h00, delay_valid, 4'h0, delay_cfg, 6'h00, delay_result};
      `BDCR_OFF_PUMP: rd = pump;
      `BDCR_OFF_PCLK: rd = pclk;
      `BDCR_OFF_PROT: rd = prot;
      default:
      begin
        rd = 32'h00000000;
        rd_bad = 1'b1;
      end
    endcase
  end
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= 2'h0;
    end
    else if (CE)
    begin
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RDATA <= rd;
        RRESP <= rd_bad ? 2'h2 : 2'h0;
      end
      else if (RREADY)
        RVALID <= 1'b0;
    end
  end
endmodule // bdcr_regs

// *** test/bdcr_regs_assertions.sv ***
// Port-level checker for the bridge config bank
// Assumes it is bound to bdcr_regs, one clock domain on MCLK
`timescale 1ns/10ps
module bdcr_regs_assertions
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // Bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  // Bridge and pump side
  input wire logic BRIDGE_REQ,
  input wire logic BRIDGE_ENABLE,
  input wire logic PUMP_UV_COMP,
  input wire logic PUMP_UV_CONV,
  input wire logic PUMP_UV,
  input wire logic PUMP_CLK,
  input wire logic PUMP_POWER_ON,
  input wire logic [2:0] SEQ_ROUTE
);
  // All checks sample on MCLK; all but the reset check rest during reset
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  // Write answers two cycles after address and data are taken together, always OKAY
  property p_wr_resp;
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID && BRESP == 2'h0;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
  // Read answers one cycle after the address is taken
  property p_rd_resp;
    ARVALID && ARREADY |=> RVALID && RRESP inside {2'h0, 2'h2};
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
  // No new write taken while a response is pending
  property p_aw_block;
    BVALID |-> !AWREADY && !WREADY;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  // Bridge stays off once its request has been low for a while
  property p_bridge_req;
    !BRIDGE_REQ [*4] |=> !BRIDGE_ENABLE;
  endproperty
  a_bridge_req: assert property (p_bridge_req) else $error("bridge on without request");
  // Reset drives the control outputs low
  property p_rst_out;
    disable iff (1'b0) !NRST |=> !PUMP_POWER_ON && !BRIDGE_ENABLE && SEQ_ROUTE == 3'h0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output not cleared by reset");
  // Pump clock half period is at least one 20 MHz tick
  property p_pclk_hold;
    $changed(PUMP_CLK) |=> $stable(PUMP_CLK) [*4];
  endproperty
  a_pclk_hold: assert property (p_pclk_hold) else $error("pump clock edge too soon");
  // Undervoltage only after a filtered source level
  property p_uv_src;
    $rose(PUMP_UV) |-> $past(PUMP_UV_COMP || PUMP_UV_CONV, 3) &&
      $past(PUMP_UV_COMP || PUMP_UV_CONV, 300);
  endproperty
  a_uv_src: assert property (p_uv_src) else $error("undervoltage without source");
  // Pump power and sequencer route outputs move only just after a write
  property p_out_change;
    $changed({PUMP_POWER_ON, SEQ_ROUTE}) |->
      BVALID || $past(BVALID) || $past(BVALID, 2) || $past(BVALID, 3);
  endproperty
  a_out_change: assert property (p_out_change) else $error("output moved without write");
  ////////////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  c_pclk: cover property ($changed(PUMP_CLK));
  c_uv: cover property ($rose(PUMP_UV));
  c_bridge: cover property ($rose(BRIDGE_ENABLE));
endmodule // bdcr_regs_assertions

bind bdcr_regs bdcr_regs_assertions u_chk (.MCLK, .NRST, .AWVALID, .AWREADY, .WVALID,
  .WREADY, .BRESP, .BVALID, .ARVALID, .ARREADY, .RRESP, .RVALID, .BRIDGE_REQ,
  .BRIDGE_ENABLE, .PUMP_UV_COMP, .PUMP_UV_CONV, .PUMP_UV, .PUMP_CLK, .PUMP_POWER_ON,
  .SEQ_ROUTE);

// *** test/tb.sv ***
// Self-checking bench for the bridge config bank
// Assumes bdcr_regs and bdcr_defines.svh on the include path
`timescale 1ns/10ps
`include "bdcr_defines.svh"
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("FAIL %0t got %0h exp %0h", $time, g, e); \
  end \
end
module tb;
  // Stimulus; bus ready lines held high throughout
  logic MCLK = 1'b0, NRST = 1'b0, CE = 1'b1, AWVALID = 1'b0, WVALID = 1'b0;
  logic BREADY = 1'b1, ARVALID = 1'b0, RREADY = 1'b1, PWM_ENABLES_ANY = 1'b0;
  logic SWITCH_ON_EVENT = 1'b0, PUMP_READY = 1'b0, PUMP_UV_CONV = 1'b0;
  logic PUMP_UV_COMP = 1'b0, SUPPLY_LOW = 1'b0, BRIDGE_REQ = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, PWM_IN_LOW = 8'h00, PWM_IN_HIGH = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hF;
  logic [2:0] ACTIVE_HIGH_SIDE = 3'h0;
  logic [5:0] GATE_ON = 6'h00;
  // Observed outputs
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PHASE3_LOW_PWM, PHASE3_HIGH_PWM;
  logic PUMP_POWER_ON, PUMP_FALL_THRESHOLD, PUMP_SINGLE_STAGE, PUMP_UV, BRIDGE_ENABLE;
  logic PUMP_CLK;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA, rd_data;
  logic [2:0] SEQ_ROUTE;
  logic [1:0] rd_resp;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  bdcr_regs dut (.MCLK, .NRST, .CE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .PWM_ENABLES_ANY, .PWM_IN_LOW, .PWM_IN_HIGH, .ACTIVE_HIGH_SIDE,
    .SWITCH_ON_EVENT, .GATE_ON, .PUMP_READY, .PUMP_UV_CONV, .PUMP_UV_COMP, .SUPPLY_LOW,
    .BRIDGE_REQ, .PHASE3_LOW_PWM, .PHASE3_HIGH_PWM, .SEQ_ROUTE, .PUMP_POWER_ON,
    .PUMP_FALL_THRESHOLD, .PUMP_SINGLE_STAGE, .PUMP_UV, .BRIDGE_ENABLE, .PUMP_CLK);
  // 100 MHz clock
  initial forever #5 MCLK = ~MCLK;
  // Hang guard
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // Bus write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    forever
    begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
  endtask
  // Bus read: data and response taken at the answer edge
  task automatic rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    forever
    begin
      @(posedge MCLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID === 1'b1) break;
    end
    rd_data = RDATA;
    rd_resp = RRESP;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_data, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped word and writable masks
  task automatic t_regs();
    logic [7:0] a [4] = '{`BDCR_OFF_SEQUENCER_MAPPING, `BDCR_OFF_PUMP, `BDCR_OFF_PCLK, `BDCR_OFF_PROT};
    logic [31:0] m [4] = '{`BDCR_MASK_SEQUENCER_MAPPING, `BDCR_MASK_PUMP, `BDCR_MASK_PCLK,
      `BDCR_MASK_PROT};
    rchk(`BDCR_OFF_PWMSRC, `BDCR_RST_PWMSRC & `BDCR_MASK_PWMSRC);
    rchk(`BDCR_OFF_SEQUENCER_MAPPING, 32'h0);
    rchk(`BDCR_OFF_DELAY, 32'h0);
    rchk(`BDCR_OFF_PUMP, 32'h0);
    rchk(`BDCR_OFF_PCLK, `BDCR_RST_PCLK);
    rchk(`BDCR_OFF_PROT, `BDCR_RST_PROT);
    wr(8'h24, 32'hFFFFFFFF);
    rchk(8'h24, 32'h0);
    `CHK(rd_resp, 2'h2)
    foreach (a[i])
    begin
      wr(a[i], 32'hFFFFFFFF);
      rchk(a[i], m[i]);
    end
    wr(`BDCR_OFF_PROT, `BDCR_RST_PROT);
    // Stop the pump clock low so later clock checks start from rest
    wr(`BDCR_OFF_PCLK, 32'h0);
  endtask
  // Phase-3 source codes, inversion on code 3, write lock
  task automatic t_src();
    for (int c = 0; c < 8; c++)
    begin
      PWM_IN_LOW <= 8'h5A;
      PWM_IN_HIGH <= 8'hA5;
      wr(`BDCR_OFF_PWMSRC, (32'(c) << 20) | (32'(c) << 16));
      rchk(`BDCR_OFF_PWMSRC, (32'(c) << 20) | (32'(c) << 16));
      for (int p = 0; p < 2; p++)
      begin
        wait_cyc(4);
        `CHK(PHASE3_LOW_PWM, PWM_IN_LOW[c] ^ (c == 3))
        `CHK(PHASE3_HIGH_PWM, PWM_IN_HIGH[c])
        PWM_IN_LOW <= ~PWM_IN_LOW;
        PWM_IN_HIGH <= ~PWM_IN_HIGH;
      end
    end
    PWM_ENABLES_ANY <= 1'b1;
    wr(`BDCR_OFF_PWMSRC, 32'h00110000);
    rchk(`BDCR_OFF_PWMSRC, 32'h00770000);
    PWM_ENABLES_ANY <= 1'b0;
  endtask
  // Sequencer routes and active side captured only at switch-on
  task automatic t_seq();
    wr(`BDCR_OFF_SEQUENCER_MAPPING, 32'h00010100);
    wait_cyc(4);
    `CHK(SEQ_ROUTE, 3'b110)
    ACTIVE_HIGH_SIDE <= 3'b101;
    SWITCH_ON_EVENT <= 1'b1;
    wait_cyc(4);
    SWITCH_ON_EVENT <= 1'b0;
    wait_cyc(4);
    rchk(`BDCR_OFF_SEQUENCER_MAPPING, 32'h00030102);
    ACTIVE_HIGH_SIDE <= 3'b010;
    wait_cyc(6);
    rchk(`BDCR_OFF_SEQUENCER_MAPPING, 32'h00030102);
  endtask
  // One delay measurement of a 2 us gate pulse
  task automatic meas(input logic [2:0] ch, input logic dir, input int g);
    GATE_ON[g] <= ~dir;
    wait_cyc(4);
    wr(`BDCR_OFF_DELAY, 32'h02000000 | (32'({dir, ch}) << 16));
    rd(`BDCR_OFF_DELAY);
    `CHK(rd_data[31:16], 16'({dir, ch}))
    GATE_ON[g] <= dir;
    wait_cyc(200);
    GATE_ON[g] <= ~dir;
    wait_cyc(10);
    rd(`BDCR_OFF_DELAY);
    `CHK(rd_data[24], ch[1:0] != 2'd0)
    if (ch[1:0] != 2'd0)
      `CHK(rd_data[9:0] inside {10'd38, 10'd39, 10'd40}, 1'b1)
  endtask
  task automatic t_delay();
    meas(3'd1, 1'b1, 0);
    meas(3'd7, 1'b0, 5);
    meas(3'd3, 1'b0, 2);
    meas(3'd4, 1'b1, 0);
    wr(`BDCR_OFF_DELAY, 32'h04000000);
    rd(`BDCR_OFF_DELAY);
    `CHK(rd_data & 32'hFFFFFC00, 32'h01000000)
    wr(`BDCR_OFF_DELAY, 32'h0);
    rd(`BDCR_OFF_DELAY);
    `CHK(rd_data & 32'hFFFFFC00, 32'h01000000)
  endtask
  // Pump power, threshold and stage selection
  task automatic t_pump();
    wr(`BDCR_OFF_PUMP, 32'h00010101);
    wait_cyc(4);
    `CHK({PUMP_POWER_ON, PUMP_FALL_THRESHOLD, PUMP_SINGLE_STAGE}, 3'b111)
    wr(`BDCR_OFF_PUMP, 32'h00030000);
    wait_cyc(6);
    `CHK({PUMP_POWER_ON, PUMP_FALL_THRESHOLD, PUMP_SINGLE_STAGE}, 3'b000)
    SUPPLY_LOW <= 1'b1;
    wait_cyc(6);
    `CHK(PUMP_SINGLE_STAGE, 1'b1)
  endtask
  // Undervoltage source, 8 us filter, ready gating and shutdown
  task automatic t_uv();
    PUMP_UV_COMP <= 1'b1;
    BRIDGE_REQ <= 1'b1;
    wr(`BDCR_OFF_PUMP, 32'h00000604);
    wait_cyc(700);
    `CHK(PUMP_UV, 1'b0)
    `CHK(BRIDGE_ENABLE, 1'b0)
    wait_cyc(200);
    `CHK(PUMP_UV, 1'b1)
    PUMP_READY <= 1'b1;
    wait_cyc(6);
    `CHK(BRIDGE_ENABLE, 1'b0)
    wr(`BDCR_OFF_PUMP, 32'h00000400);
    wait_cyc(900);
    `CHK({PUMP_UV, BRIDGE_ENABLE}, 2'b01)
    PUMP_UV_CONV <= 1'b1;
    wait_cyc(900);
    `CHK({PUMP_UV, BRIDGE_ENABLE}, 2'b10)
    wr(`BDCR_OFF_PROT, 32'h0);
    wait_cyc(6);
    `CHK(BRIDGE_ENABLE, 1'b1)
    BRIDGE_REQ <= 1'b0;
    wait_cyc(6);
    `CHK(BRIDGE_ENABLE, 1'b0)
  endtask
  // Cycles until the pump clock next changes
  task automatic gap(output int n);
    logic p;
    p = PUMP_CLK;
    n = 0;
    do
    begin
      @(posedge MCLK);
      n++;
    end while (PUMP_CLK === p && n < 1000);
  endtask
  // Pump clock idle levels, prohibited range, dithered halves
  task automatic t_pclk();
    int n;
    int s;
    wr(`BDCR_OFF_PCLK, 32'h00020000);
    wait_cyc(12);
    `CHK(PUMP_CLK, 1'b1)
    wr(`BDCR_OFF_PCLK, 32'h0);
    wait_cyc(12);
    `CHK(PUMP_CLK, 1'b0)
    wr(`BDCR_OFF_PCLK, 32'h00010204);
    gap(n);
    `CHK(n, 1000)
    wr(`BDCR_OFF_PCLK, 32'h00012204);
    gap(n);
    s = 0;
    repeat (4)
    begin
      gap(n);
      s += n;
    end
    `CHK(s, 700)
    // Clock enable low freezes the divider
    CE <= 1'b0;
    gap(n);
    `CHK(n, 1000)
    CE <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, with a second reset at the end
  initial
  begin
    wait_cyc(5);
    NRST <= 1'b1;
    t_regs();
    t_src();
    t_seq();
    t_delay();
    t_pump();
    t_uv();
    t_pclk();
    NRST <= 1'b0;
    wait_cyc(5);
    NRST <= 1'b1;
    rchk(`BDCR_OFF_PCLK, `BDCR_RST_PCLK);
    rchk(`BDCR_OFF_PROT, `BDCR_RST_PROT);
    results();
  end
endmodule // tb
